// ===== design/hsdp_port.sv
// What this block does
// RL1: shift the serial input into a 32-bit register on rising serial clock
// RL2: on select rising, copy shift register to holding buffer and execute
// RL3: present next output bit 2.5 to 3.5 clocks after serial clock falls; the port takes 2 to 3 clocks
// RL4: host samples the output bit on its rising serial clock edge
// RL5: host keeps serial clock low and high at least 3 clocks each
// RL6: serial signals are asynchronous; sample and synchronise them inside
// RL7: host should make each serial clock period at least 8 clocks
// RL8: host holds select and serial clock high while idle
// RL9: while select is high, drive the low-active interrupt status out
// RL10: interrupt status valid on output within 4.5 clocks of select rising
// RL11: host sets input valid at rising edge; no upper period limit
// RL12: host limits serial clock to 1MHz at 16MHz, 2MHz at 32MHz; the host model runs 125 ns periods on a 10 ns clock
// RL13: host holds select high 3 clocks, then starts by pulling it low
// RL14: host waits 3 clocks after select low before first clock fall
// RL15: datagrams are exactly 32 bits, most significant bit first
// RL16: host raises select at least 3 clocks after last rising edge
// RL17: the output pin is always driven, never high impedance
// RL18: reply is 32 bits: 8 status bits high, 24 read data bits low
// RL19: read/not-write bit 1 requests a read, 0 a write
// RL20: the top datagram bit selects register set or on-chip ram
// RL21: select 0 routes to registers, 1 routes to on-chip ram
// RL22: read requests ignore the data bits; host drives them zero
// RL23: narrow registers use a subset of data bits; host zeroes the rest
// RL24: bit 31 select, bits 30..25 address, bit 24 rw, bits 23..0 data
//
// top of the host serial datagram port, device end
// assumes the register set answers rd_data_in in the same cycle as acc_rd_out
`timescale 1ns/1ps
`default_nettype none

`include "hsdp_defs.svh"

module hsdp_port (
  input  wire logic                          clk_sys_in,
  input  wire logic                          nrst_in,
  input  wire logic                          host_sclk_in,
  input  wire logic                          host_select_n_in,
  input  wire logic                          host_data_in,
  input  wire logic                          irq_in,
  input  wire logic [`HSDP_STAT_BITS-1:0]    status_in,
  input  wire logic [`HSDP_DATA_BITS-1:0]    rd_data_in,
  output logic                               shared_out_irq_pin_out,
  output logic                               acc_rd_out,
  output logic                               acc_wr_out,
  output logic                               acc_space_out,
  output logic [`HSDP_ADDR_BITS-1:0]         acc_addr_out,
  output logic [`HSDP_DATA_BITS-1:0]         acc_wdata_out
);

  // ==========================================================
  // declarations
  hsdp_pkg::hsdp_state_type state;
  hsdp_pkg::hsdp_state_type next_state;
  hsdp_pkg::hsdp_word_type  rx_word;
  hsdp_pkg::hsdp_word_type  hold;
  hsdp_pkg::hsdp_word_type  next_hold;
  hsdp_pkg::hsdp_word_type  tx_word;
  hsdp_pkg::hsdp_word_type  next_tx_word;
  logic [`HSDP_CNT_BITS-1:0] bit_cnt;
  logic [`HSDP_CNT_BITS-1:0] next_bit_cnt;
  logic [`HSDP_HDR_BITS-1:0] hdr;
  logic [`HSDP_HDR_BITS-1:0] next_hdr;
  logic                     fetch;
  logic                     next_fetch;
  logic                     next_pin;
  logic                     next_rd;
  logic                     next_wr;
  logic                     next_space;
  logic [`HSDP_ADDR_BITS-1:0] next_addr;
  logic [`HSDP_DATA_BITS-1:0] next_wdata;
  logic                     sclk_s;
  logic                     sclk_d;
  logic                     sel_n_s;
  logic                     data_s;
  logic                     sclk_rise;
  logic                     sclk_fall;

  // ==========================================================
  // serial clock domain: the datagram shift register
  hsdp_rx_shift u_rx (
    .host_sclk_in     (host_sclk_in),
    .host_select_n_in (host_select_n_in),
    .host_data_in     (host_data_in),
    .shift_out        (rx_word)
  );

  // ==========================================================
  // pin synchronisers; idle level of select and clock is high
  hsdp_sync u_sync_sclk (                      // see RL6
    .clk_in     (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   (host_sclk_in),
    .rst_val_in (1'h1),
    .sync_out   (sclk_s)
  );

  hsdp_sync u_sync_sel (                       // see RL6
    .clk_in     (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   (host_select_n_in),
    .rst_val_in (1'h1),
    .sync_out   (sel_n_s)
  );

  hsdp_sync u_sync_data (                      // see RL6
    .clk_in     (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   (host_data_in),
    .rst_val_in (1'h0),
    .sync_out   (data_s)
  );

  // edges are taken from the second stage and a delayed copy of it
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;

  // ==========================================================
  // frame control, header capture, read fetch and reply
  always_comb
  begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_hdr     = hdr;
    next_hold    = hold;
    next_tx_word = tx_word;
    next_fetch   = 1'h0;
    next_rd      = 1'h0;
    next_wr      = 1'h0;
    next_space   = acc_space_out;
    next_addr    = acc_addr_out;
    next_wdata   = acc_wdata_out;
    next_pin     = shared_out_irq_pin_out;
    unique case (state)
      hsdp_pkg::HSDP_IDLE:
      begin
        next_pin = ~irq_in;                               // see RL9
        if (!sel_n_s)
        begin
          next_state   = hsdp_pkg::HSDP_FRAME;
          next_bit_cnt = '0;
          // reply starts as status over zeros; read data joins later
          next_tx_word = {status_in, {`HSDP_DATA_BITS{1'h0}}}; // see RL18
          next_pin     = status_in[`HSDP_STAT_BITS-1];    // see RL15
        end
      end
      hsdp_pkg::HSDP_FRAME:
      begin
        if (sel_n_s)
        begin
          // select rose: the serial clock is quiet, so the word is stable
          next_state = hsdp_pkg::HSDP_IDLE;
          next_pin   = ~irq_in;                           // see RL10
          next_hold  = rx_word;                           // see RL2
          // a read frame never reaches the write data: see RL22
          if (rx_word[`HSDP_RW_POS] != `HSDP_RW_READ)     // see RL19
          begin
            next_wr    = 1'h1;
            next_space = rx_word[`HSDP_SPACE_POS];        // see RL20
            next_addr  = rx_word[`HSDP_ADDR_HI:`HSDP_ADDR_LO]; // see RL24
            next_wdata = rx_word[`HSDP_DATA_HI:0];        // see RL23
          end
        end
        else
        begin
          if (sclk_rise && bit_cnt != `HSDP_LAST_BIT)
          begin
            next_bit_cnt = bit_cnt + 6'h01;
            if (bit_cnt < `HSDP_HDR_BITS)
              next_hdr = {hdr[`HSDP_HDR_BITS-2:0], data_s};
            // header complete on the eighth rising edge
            next_fetch = (bit_cnt == `HSDP_HDR_BITS - 6'h01);
          end
          // the first fall presents the msb again; later falls move on
          if (sclk_fall && bit_cnt < `HSDP_LAST_BIT)
            next_pin = tx_word[5'h1f - bit_cnt[4:0]];     // see RL3
          // a read asks the register set while the status bits go out
          if (fetch && hdr[0] == `HSDP_RW_READ)           // see RL19
          begin
            next_rd    = 1'h1;
            next_space = hdr[`HSDP_HDR_BITS-1];           // see RL21
            next_addr  = hdr[`HSDP_HDR_BITS-2:1];         // see RL24
          end
          // read data arrives in the same cycle as the request, before bit 23
          if (acc_rd_out)
            next_tx_word[`HSDP_DATA_HI:0] = rd_data_in;   // see RL18
        end
      end
    endcase
    if (!nrst_in)
    begin
      next_state   = hsdp_pkg::HSDP_IDLE;
      next_bit_cnt = '0;
      next_hdr     = '0;
      next_hold    = '0;
      next_tx_word = '0;
      next_fetch   = 1'h0;
      next_rd      = 1'h0;
      next_wr      = 1'h0;
      next_space   = 1'h0;
      next_addr    = '0;
      next_wdata   = '0;
      next_pin     = 1'h1;  // pin is driven from reset on, see RL17
    end
  end

  // only registers; the pin flop never releases the line
  always_ff @(posedge clk_sys_in)
  begin
    state                  <= next_state;
    bit_cnt                <= next_bit_cnt;
    hdr                    <= next_hdr;
    hold                   <= next_hold;
    tx_word                <= next_tx_word;
    fetch                  <= next_fetch;
    acc_rd_out             <= next_rd;
    acc_wr_out             <= next_wr;
    acc_space_out          <= next_space;
    acc_addr_out           <= next_addr;
    acc_wdata_out          <= next_wdata;
    shared_out_irq_pin_out <= next_pin;                   // see RL17
    sclk_d                 <= nrst_in ? sclk_s : 1'h1;
  end

endmodule : hsdp_port

`default_nettype wire

// ===== design/hsdp_defs.svh
// constants of the host serial datagram port: frame layout and widths
// assumes inclusion by bare name from the package and design modules
`ifndef HSDP_DEFS_SVH
`define HSDP_DEFS_SVH

// frame geometry
`define HSDP_FRAME_BITS   32
`define HSDP_CNT_BITS     6
`define HSDP_HDR_BITS     6'h08
`define HSDP_LAST_BIT     6'h20

// incoming datagram fields
`define HSDP_SPACE_POS    31
`define HSDP_ADDR_HI      30
`define HSDP_ADDR_LO      25
`define HSDP_ADDR_BITS    6
`define HSDP_RW_POS       24
`define HSDP_DATA_HI      23
`define HSDP_DATA_BITS    24
`define HSDP_STAT_BITS    8

// field encodings
`define HSDP_RW_READ      1'h1
`define HSDP_SPACE_RAM    1'h1

`endif

// ===== design/hsdp_pkg.sv
// types of the host serial datagram port
// assumes the constants header sits beside it
`include "hsdp_defs.svh"

package hsdp_pkg;

  // frame state as seen from the system clock
  typedef enum logic [0:0] {
    HSDP_IDLE,
    HSDP_FRAME
  } hsdp_state_type;

  typedef logic [`HSDP_FRAME_BITS-1:0] hsdp_word_type;

endpackage : hsdp_pkg

// ===== design/hsdp_sync.sv
// two-flop level synchroniser for one asynchronous pin
// assumes the pin has no phase relation to clk_in
`timescale 1ns/1ps
`default_nettype none

module hsdp_sync (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic async_in,
  input  wire logic rst_val_in,
  output logic      sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync;

  // ==========================================================
  // the first stage is read by the second stage only
  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
    if (!nrst_in)
    begin
      next_meta = rst_val_in;
      next_sync = rst_val_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    meta     <= next_meta;
    sync_out <= next_sync;
  end

endmodule : hsdp_sync

`default_nettype wire

// ===== design/hsdp_rx_shift.sv
// datagram shift register clocked by the host serial clock
// assumes select goes low well before the first serial clock edge
`timescale 1ns/1ps
`default_nettype none

`include "hsdp_defs.svh"

module hsdp_rx_shift (
  input  wire logic                         host_sclk_in,
  input  wire logic                         host_select_n_in,
  input  wire logic                         host_data_in,
  output hsdp_pkg::hsdp_word_type           shift_out
);

  hsdp_pkg::hsdp_word_type next_shift;

  // ==========================================================
  // shift msb first on each rising serial clock edge while select is low
  always_comb
  begin
    next_shift = shift_out;
    if (!host_select_n_in)
      next_shift = {shift_out[`HSDP_FRAME_BITS-2:0], host_data_in}; // see RL1
  end

  // no reset: the serial clock may stand still, and the word is data only
  always_ff @(posedge host_sclk_in)
  begin
    shift_out <= next_shift;
  end

endmodule : hsdp_rx_shift

`default_nettype wire

// ===== test/hsdp_checker.sv
// checker: port timing and execution of the datagram port
// assumes a bind onto hsdp_port; sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "hsdp_defs.svh"

module hsdp_checker (
  input wire logic                       clk_sys_in,
  input wire logic                       nrst_in,
  input wire logic                       host_sclk_in,
  input wire logic                       host_select_n_in,
  input wire logic                       host_data_in,
  input wire logic                       irq_in,
  input wire logic [`HSDP_STAT_BITS-1:0] status_in,
  input wire logic [`HSDP_DATA_BITS-1:0] rd_data_in,
  input wire logic                       shared_out_irq_pin_out,
  input wire logic                       acc_rd_out,
  input wire logic                       acc_wr_out,
  input wire logic                       acc_space_out,
  input wire logic [`HSDP_ADDR_BITS-1:0] acc_addr_out,
  input wire logic [`HSDP_DATA_BITS-1:0] acc_wdata_out
);
  // ====
  // helpers
  hsdp_pkg::hsdp_word_type sh;
  logic [3:0]              age;
  logic                    sclk_q;
  // shadow of the wire; settled long before select rises
  always_ff @(posedge host_sclk_in)
    sh <= {sh[30:0], host_data_in};
  // clocks since a falling serial clock was sampled, saturating
  always_ff @(posedge clk_sys_in)
  begin
    sclk_q <= host_sclk_in;
    age    <= (sclk_q && !host_sclk_in) ? 4'h0 : age + 4'(age != 4'hf);
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  a_idle_irq: assert property (host_select_n_in [*5] |->
    shared_out_irq_pin_out == !$past(irq_in)) else $error("idle pin");
  a_irq_after_sel: assert property ($rose(host_select_n_in) |->
    ##3 shared_out_irq_pin_out == !$past(irq_in)) else $error("late irq");
  a_write_exec: assert property ($rose(host_select_n_in) && !sh[24] |->
    ##[1:3] acc_wr_out && acc_space_out == sh[31] &&
    acc_addr_out == sh[30:25] && acc_wdata_out == sh[23:0])
    else $error("write lost");
  a_read_no_write: assert property ($rose(host_select_n_in) && sh[24] |->
    ##1 !acc_wr_out [*4]) else $error("write on read");
  a_pulse_single: assert property (acc_rd_out || acc_wr_out |=>
    !(acc_rd_out || acc_wr_out)) else $error("long pulse");
  a_read_fetch: assert property (acc_rd_out |-> sh[0] &&
    acc_space_out == sh[7] && acc_addr_out == sh[6:1]) else $error("bad read");
  a_bit_timing: assert property ($changed(shared_out_irq_pin_out) &&
    !host_select_n_in && !$past(host_select_n_in, 6) |->
    age >= 4'h1 && age <= 4'h4) else $error("bit timing");
  a_start_status: assert property ($fell(host_select_n_in) |-> ##4
    shared_out_irq_pin_out == status_in[7]) else $error("status bit");
  c_read_ram: cover property (acc_rd_out && acc_space_out);
  c_write_reg: cover property (acc_wr_out && !acc_space_out);
  c_irq_low: cover property (host_select_n_in && !shared_out_irq_pin_out);
endmodule : hsdp_checker

bind hsdp_port hsdp_checker i_chk (.*);
`default_nettype wire

// ===== test/hsdp_host.sv
// host model: frame master with its own 125 ns serial clock
// assumes a 10 ns device clock; clock stands high between frames
`timescale 1ns/1ps
`default_nettype none

module hsdp_host (
  input  wire logic pin_in,
  output var logic  sclk_out,
  output var logic  select_n_out,
  output var logic  data_out
);
  hsdp_pkg::hsdp_word_type rx_word;
  event                    done;
  // idle levels from time zero
  initial
  begin
    sclk_out     = 1'b1;
    select_n_out = 1'b1;
    data_out     = 1'b0;
  end
  // ====
  // one whole frame; odd offset keeps edges off the device clock
  task automatic xfer(input hsdp_pkg::hsdp_word_type tx);
    #7.3 select_n_out = 1'b0;
    #40;
    for (int i = 31; i >= 0; i--)
    begin
      sclk_out = 1'b0;
      data_out = tx[i];
      #62.5 sclk_out = 1'b1;
      rx_word[i] = pin_in;
      #62.5;
    end
    select_n_out = 1'b1;
    data_out     = ~data_out; // released line must not look held
    #40 -> done;
  endtask : xfer
endmodule : hsdp_host
`default_nettype wire

// ===== test/tb_top.sv
// bench: random frames of all four kinds through the host model
// assumes design files, checker and host model compile first
`timescale 1ns/1ps
`default_nettype none
`include "hsdp_defs.svh"

module tb_top;
  logic                        clk_sys_in = 1'b0;
  logic                        nrst_in    = 1'b0;
  logic                        irq_in     = 1'b0;
  logic [`HSDP_STAT_BITS-1:0]  status_in  = 8'h00;
  logic [`HSDP_DATA_BITS-1:0]  rd_data_in = 24'h000000;
  logic [31:0]                 lfsr       = 32'h29b0;
  logic [32:0]                 q_acc[$];
  hsdp_pkg::hsdp_word_type     q_rep[$];
  int                          fails      = 0;
  int                          cmp_count  = 0;
  int                          cycles     = 0;
  wire logic                   sclk, sel_n, sdi, pin, rd, wr, space;
  wire logic [5:0]             addr;
  wire logic [23:0]            wd;
  hsdp_host i_host (.pin_in(pin), .sclk_out(sclk), .select_n_out(sel_n),
    .data_out(sdi));
  hsdp_port i_dut (.clk_sys_in, .nrst_in, .host_sclk_in(sclk),
    .host_select_n_in(sel_n), .host_data_in(sdi), .irq_in, .status_in,
    .rd_data_in, .shared_out_irq_pin_out(pin), .acc_rd_out(rd),
    .acc_wr_out(wr), .acc_space_out(space), .acc_addr_out(addr),
    .acc_wdata_out(wd));
  always #5 clk_sys_in = ~clk_sys_in;
  // ====
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : lfsr_next
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // driver: frames of every space and direction, boundary addresses first
  initial
  begin
    logic [31:0] w;
    logic [23:0] last_wd;
    last_wd = 24'h000000;
    repeat (16) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    for (int i = 0; i < 16; i++)
    begin
      lfsr = lfsr_next(lfsr);
      w = lfsr;
      w[31] = i[1];
      w[24] = i[0];
      if (i < 4)
        w[30:25] = i[0] ? 6'h3f : 6'h00;
      if (w[24])
        w[23:0] = 24'h000000;
      lfsr = lfsr_next(lfsr);
      status_in  <= lfsr[31:24];
      rd_data_in <= lfsr[23:0];
      irq_in     <= lfsr[5];
      q_rep.push_back({lfsr[31:24], w[24] ? lfsr[23:0] : 24'h000000});
      q_acc.push_back({w[24], !w[24], w[31], w[30:25],
        w[24] ? last_wd : w[23:0]});
      if (!w[24])
        last_wd = w[23:0];
      @(posedge clk_sys_in);
      i_host.xfer(w);
      repeat (12) @(posedge clk_sys_in);
    end
    check({32'h0, q_acc.size() == 0 && q_rep.size() == 0}, 33'h1);
    complete_run();
  end
  // watcher: each access pulse against the oldest noted access
  always @(negedge clk_sys_in)
    if (rd === 1'b1 || wr === 1'b1)
      check({rd, wr, space, addr, wd}, q_acc.pop_front());
  // watcher: each reply, then the idle pin level
  initial
    forever
    begin
      @(i_host.done);
      check({1'b0, i_host.rx_word}, {1'b0, q_rep.pop_front()});
      repeat (6) @(negedge clk_sys_in);
      check({32'h0, pin}, {32'h0, ~irq_in});
    end
  // hang guard, well above sixteen frames of about 420 clocks
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end
endmodule : tb_top
`default_nettype wire
